//--- disp_bus_dev.sv
// disp_bus_dev: device end of the display host bus, all four modes
// assumes the link pins are asynchronous and change slower than 8 clocks
`timescale 1ns/1ns
module disp_bus_dev (
	// system
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// link
	disp_bus_if.dev bus,
	// received bytes
	output logic wr_valid_o,
	output logic [7:0] wr_byte_o,
	output logic wr_is_data_o,
	// read requests
	output logic rd_req_o,
	output logic rd_is_data_o,
	input wire logic [7:0] rd_data_i,
	// status
	output disp_bus_pkg::mode_t mode_o,
	output logic init_active_o
);
	import disp_bus_pkg::*;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [14:0] pin_raw;
	logic [14:0] pin_meta;
	logic [14:0] pin_sync;
	logic [14:0] pin_prev;
	logic res_s, bsh_s, bsl_s, cs_s, dc_s, rw_s, en_s;
	logic res_p, bsh_p, bsl_p, cs_p, dc_p, rw_p, en_p;
	logic [7:0] d_s;
	logic [7:0] d_p;

	assign pin_raw = {bus.reset_in_n, bus.bus_select_high, bus.bus_select_low, bus.cs_n,
		bus.dc, bus.rw, bus.en, bus.d};
	assign {res_s, bsh_s, bsl_s, cs_s, dc_s, rw_s, en_s, d_s} = pin_sync;
	assign {res_p, bsh_p, bsl_p, cs_p, dc_p, rw_p, en_p, d_p} = pin_prev;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pin_meta <= SYNC_RST;
			pin_sync <= SYNC_RST;
			pin_prev <= SYNC_RST;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// ************************************************************
	// bus state
	// ************************************************************
	mode_t mode, next_mode;
	i2c_st_t ist, next_ist;
	logic pend, next_pend;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] d_out, next_d_out;
	logic [7:0] d_oe, next_d_oe;
	logic wr_valid, next_wr_valid;
	logic [7:0] wr_byte, next_wr_byte;
	logic wr_is_data, next_wr_is_data;
	logic rd_req, next_rd_req;
	logic rd_is_data, next_rd_is_data;
	logic rst;
	logic sel;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;

	assign rst = ~resetn_i | ~res_s;
	assign sel = ~cs_s;
	assign scl_rise = rose(d_s[PIN_CLK], d_p[PIN_CLK]);
	assign scl_fall = rose(d_p[PIN_CLK], d_s[PIN_CLK]);
	assign i2c_start = d_s[PIN_CLK] & d_p[PIN_CLK] & rose(d_p[PIN_SIN], d_s[PIN_SIN]);
	assign i2c_stop = d_s[PIN_CLK] & d_p[PIN_CLK] & rose(d_s[PIN_SIN], d_p[PIN_SIN]);

	always_comb begin
		next_mode = mode;
		next_ist = ist;
		next_pend = pend;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_d_out = d_out;
		next_d_oe = d_oe;
		next_wr_valid = 1'b0;
		next_wr_byte = wr_byte;
		next_wr_is_data = wr_is_data;
		next_rd_req = 1'b0;
		next_rd_is_data = rd_is_data;
		// straps followed while the device is held in init
		if (!res_s) begin
			next_mode = mode_t'({bsh_s, bsl_s});
		end
		unique case (mode)
			MODE_6800: begin
				if (sel && rose(en_s, en_p)) begin
					if (rw_s) begin
						next_rd_req = 1'b1;
						next_rd_is_data = dc_s;
						next_d_out = rd_data_i;
					end else begin
						next_pend = 1'b1;
					end
				end
				// write byte latched as enable falls
				if (pend && rose(en_p, en_s)) begin
					next_wr_valid = 1'b1;
					next_wr_byte = d_s;
					next_wr_is_data = dc_s;
				end
				if (!sel || rose(en_p, en_s)) begin
					next_pend = 1'b0;
				end
				next_d_oe = {DATA_W{sel & en_s & rw_s}};
			end
			MODE_8080: begin
				if (sel && rose(rw_p, rw_s)) begin
					next_pend = 1'b1;
				end
				// write byte latched as write strobe rises
				if (pend && rose(rw_s, rw_p)) begin
					next_wr_valid = 1'b1;
					next_wr_byte = d_s;
					next_wr_is_data = dc_s;
				end
				if (!sel || rose(rw_s, rw_p)) begin
					next_pend = 1'b0;
				end
				if (sel && rose(en_p, en_s)) begin
					next_rd_req = 1'b1;
					next_rd_is_data = dc_s;
					next_d_out = rd_data_i;
				end
				next_d_oe = {DATA_W{sel & ~en_s & rw_s}};
			end
			MODE_SPI4: begin
				next_d_oe = '0;
				if (!sel) begin
					next_bitcnt = '0;
				end else if (scl_rise) begin
					next_shreg = {shreg[DATA_W-2:0], d_s[PIN_SIN]};
					if (bitcnt == BIT_LAST) begin
						next_bitcnt = '0;
						next_wr_valid = 1'b1;
						next_wr_byte = {shreg[DATA_W-2:0], d_s[PIN_SIN]};
						next_wr_is_data = dc_s;
					end else begin
						next_bitcnt = bitcnt + 4'h1;
					end
				end
			end
			MODE_I2C: begin
				if (i2c_start) begin
					next_ist = I2C_ADDR;
					next_bitcnt = '0;
					next_d_oe = '0;
				end else if (i2c_stop) begin
					next_ist = I2C_IDLE;
					next_d_oe = '0;
				end else begin
					unique case (ist)
						I2C_IDLE: begin
							next_d_oe = '0;
						end
						I2C_ADDR, I2C_DATA: begin
							if (scl_rise) begin
								next_shreg = {shreg[DATA_W-2:0], d_s[PIN_SIN]};
								next_bitcnt = bitcnt + 4'h1;
							end else if (scl_fall && bitcnt == BYTE_BITS) begin
								next_bitcnt = '0;
								next_ist = I2C_IDLE;
								if (ist == I2C_DATA && sel) begin
									next_wr_valid = 1'b1;
									next_wr_byte = shreg;
									next_wr_is_data = dc_s;
									next_ist = I2C_DACK;
									next_d_oe = ACK_OE;
									next_d_out = '0;
								end else if (ist == I2C_ADDR && sel
									&& shreg == {I2C_ADDR_HI, rw_s, 1'b0}) begin
									next_ist = I2C_AACK;
									next_d_oe = ACK_OE;
									next_d_out = '0;
								end
							end
						end
						I2C_AACK, I2C_DACK: begin
							if (scl_fall) begin
								next_ist = I2C_DATA;
								next_d_oe = '0;
							end
						end
						default: begin
							next_ist = I2C_IDLE;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			mode <= MODE_SPI4;
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			ist <= I2C_IDLE;
			pend <= 1'b0;
			bitcnt <= '0;
			shreg <= '0;
			d_out <= '0;
			d_oe <= '0;
			wr_valid <= 1'b0;
			wr_byte <= '0;
			wr_is_data <= 1'b0;
			rd_req <= 1'b0;
			rd_is_data <= 1'b0;
		end else begin
			ist <= next_ist;
			pend <= next_pend;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			d_out <= next_d_out;
			d_oe <= next_d_oe;
			wr_valid <= next_wr_valid;
			wr_byte <= next_wr_byte;
			wr_is_data <= next_wr_is_data;
			rd_req <= next_rd_req;
			rd_is_data <= next_rd_is_data;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign wr_valid_o = wr_valid;
	assign wr_byte_o = wr_byte;
	assign wr_is_data_o = wr_is_data;
	assign rd_req_o = rd_req;
	assign rd_is_data_o = rd_is_data;
	assign mode_o = mode;
	assign init_active_o = ~res_s;
	assign bus.dev_d_o = d_out;
	assign bus.dev_d_oe = d_oe;
endmodule : disp_bus_dev

//--- disp_bus_pkg.sv
// disp_bus_pkg: constants, modes and states of the display host bus
// assumes one 250 MHz system clock at each end; link pins cross by sampling
package disp_bus_pkg;
	localparam int CLK_NS = 4;
	localparam int LINK_HALF_NS = 64;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int RES_HOLD_NS = 100;
	localparam int RES_HOLD_CYC = (RES_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] TICK_LAST = 4'(LINK_HALF_CYC - 1);
	localparam logic [4:0] RES_LAST = 5'(RES_HOLD_CYC - 1);
	localparam int DATA_W = 8;
	localparam int PIN_CLK = 0;
	localparam int PIN_SIN = 1;
	localparam int PIN_SOUT = 2;
	localparam logic [7:0] ACK_OE = 8'h04;
	localparam logic [7:0] SPI_OE = 8'h03;
	localparam logic [7:0] SCL_OE = 8'h01;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// upper six address bits; value is arbitrary
	localparam logic [5:0] I2C_ADDR_HI = 6'h2A;
	localparam logic [5:0] STEP_STROBE = 6'h01;
	localparam logic [5:0] STEP_SAMPLE = 6'h01;
	localparam logic [5:0] PAR_LAST = 6'h03;
	localparam logic [5:0] SPI_LAST = 6'h11;
	localparam logic [5:0] I2C_BIT0 = 6'h02;
	localparam logic [5:0] I2C_PH = 6'h03;
	localparam logic [5:0] I2C_STOP = 6'h38;
	localparam logic [5:0] I2C_LAST = 6'h3A;
	localparam logic [4:0] FRAME_MSB = 5'h11;
	// {reset, sel high, sel low, cs, dc, rw, en, d}
	localparam logic [14:0] SYNC_RST = 15'h0800;

	typedef enum logic [1:0] {
		MODE_SPI4 = 2'h0,
		MODE_I2C = 2'h1,
		MODE_6800 = 2'h2,
		MODE_8080 = 2'h3
	} mode_t;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_AACK = 3'h3,
		I2C_DATA = 3'h2,
		I2C_DACK = 3'h6
	} i2c_st_t;

	function automatic logic rose(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction : rose
endpackage : disp_bus_pkg

//--- disp_bus_if.sv
// disp_bus_if: the display host bus pins between host and device
// assumes open-drain SDA with pull-up, other idle lines pulled low
`timescale 1ns/1ns
interface disp_bus_if;
	import disp_bus_pkg::*;
	logic bus_select_low;
	logic bus_select_high;
	logic reset_in_n;
	logic cs_n;
	logic dc;
	logic rw;
	logic en;
	logic [7:0] host_d_o;
	logic [7:0] host_d_oe;
	logic [7:0] dev_d_o;
	logic [7:0] dev_d_oe;
	logic [7:0] d;
	logic i2c_sel;
	logic sda_line;

	assign i2c_sel = bus_select_low & ~bus_select_high;
	// wired-and of both open-drain drivers
	assign sda_line = ~((host_d_oe[PIN_SIN] & ~host_d_o[PIN_SIN])
		| (dev_d_oe[PIN_SOUT] & ~dev_d_o[PIN_SOUT]));

	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			if (dev_d_oe[i]) begin
				d[i] = dev_d_o[i];
			end else if (host_d_oe[i]) begin
				d[i] = host_d_o[i];
			end else begin
				d[i] = 1'b0;
			end
		end
		if (i2c_sel) begin
			d[PIN_SIN] = sda_line;
			d[PIN_SOUT] = sda_line;
		end
	end

	modport dev (
		input bus_select_low, bus_select_high, reset_in_n, cs_n, dc, rw, en, d,
		output dev_d_o, dev_d_oe
	);
	modport host (
		output bus_select_low, bus_select_high, reset_in_n, cs_n, dc, rw, en,
		output host_d_o, host_d_oe,
		input d
	);
endinterface : disp_bus_if

//--- disp_bus_host.sv
// disp_bus_host: host end, runs one byte per command in the strapped mode
// assumes a 250 MHz clock; link strobes come from a divider of it
`timescale 1ns/1ns
module disp_bus_host (
	// system
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// link
	disp_bus_if.host bus,
	// mode to strap
	input disp_bus_pkg::mode_t mode_i,
	// commands
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_read_i,
	input wire logic cmd_is_data_i,
	input wire logic [7:0] cmd_byte_i,
	// read answers
	output logic rsp_valid_o,
	output logic [7:0] rsp_byte_o
);
	import disp_bus_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	mode_t strap, next_strap;
	logic [4:0] res_cnt, next_res_cnt;
	logic res_done, next_res_done;
	logic busy, next_busy;
	logic [5:0] step, next_step;
	logic [3:0] tick_cnt, next_tick_cnt;
	logic rd, next_rd;
	logic dc, next_dc;
	logic [7:0] byte_q, next_byte_q;
	logic cs_n, next_cs_n;
	logic rw, next_rw;
	logic en, next_en;
	logic [7:0] d_o, next_d_o;
	logic [7:0] d_oe, next_d_oe;
	logic rsp_valid, next_rsp_valid;
	logic [7:0] rsp_byte, next_rsp_byte;
	logic [7:0] d_meta;
	logic [7:0] d_sync;
	logic tick;
	logic last;
	logic act;
	logic scl;
	logic sda;
	logic [5:0] rel;
	logic [17:0] frame;

	assign tick = busy && tick_cnt == TICK_LAST;
	assign cmd_ready_o = res_done & ~busy;

	always_ff @(posedge clk_sys_i) begin
		d_meta <= bus.d;
		d_sync <= d_meta;
	end

	always_comb begin
		next_strap = strap;
		next_res_cnt = res_cnt;
		next_res_done = res_done;
		next_busy = busy;
		next_step = step;
		next_tick_cnt = tick_cnt;
		next_rd = rd;
		next_dc = dc;
		next_byte_q = byte_q;
		next_rsp_valid = 1'b0;
		next_rsp_byte = rsp_byte;
		last = 1'b0;
		scl = 1'b1;
		sda = 1'b1;
		if (!res_done) begin
			next_strap = mode_i;
			next_res_cnt = res_cnt + 5'h01;
			next_res_done = res_cnt == RES_LAST;
		end
		unique case (strap)
			MODE_6800, MODE_8080: last = step == PAR_LAST;
			MODE_SPI4: last = step == SPI_LAST;
			MODE_I2C: last = step == I2C_LAST;
		endcase
		if (cmd_valid_i && cmd_ready_o) begin
			next_busy = 1'b1;
			next_step = '0;
			next_tick_cnt = '0;
			next_rd = cmd_read_i;
			next_dc = cmd_is_data_i;
			next_byte_q = cmd_byte_i;
		end else if (busy) begin
			next_tick_cnt = tick ? 4'h0 : tick_cnt + 4'h1;
			if (tick && step == STEP_SAMPLE) begin
				next_rsp_byte = d_sync;
			end
			if (tick && last) begin
				next_busy = 1'b0;
				next_rsp_valid = rd & (strap == MODE_6800 || strap == MODE_8080);
			end else if (tick) begin
				next_step = step + 6'h01;
			end
		end
		// link pins for the step now being entered
		act = next_busy;
		rel = next_step - I2C_BIT0;
		frame = {I2C_ADDR_HI, 1'b0, 1'b0, 1'b1, next_byte_q, 1'b1};
		next_cs_n = 1'b1;
		next_rw = 1'b0;
		next_en = 1'b0;
		next_d_o = '0;
		next_d_oe = '0;
		unique case (strap)
			MODE_6800: begin
				if (act && next_step != PAR_LAST) begin
					next_cs_n = 1'b0;
					next_rw = next_rd;
					next_en = next_step == STEP_STROBE;
					next_d_o = next_rd ? 8'h00 : next_byte_q;
					next_d_oe = {DATA_W{~next_rd}};
				end
			end
			MODE_8080: begin
				next_rw = 1'b1;
				next_en = 1'b1;
				if (act && next_step != PAR_LAST) begin
					next_cs_n = 1'b0;
					next_rw = ~(~next_rd && next_step == STEP_STROBE);
					next_en = ~(next_rd && next_step == STEP_STROBE);
					next_d_o = next_rd ? 8'h00 : next_byte_q;
					next_d_oe = {DATA_W{~next_rd}};
				end
			end
			MODE_SPI4: begin
				next_d_oe = SPI_OE;
				if (act && next_step != SPI_LAST) begin
					next_cs_n = 1'b0;
					next_d_o[PIN_CLK] = next_step[0];
					next_d_o[PIN_SIN] = next_byte_q[3'h7 - next_step[3:1]];
				end
			end
			MODE_I2C: begin
				next_cs_n = 1'b0;
				if (act && next_step != I2C_LAST) begin
					if (next_step < I2C_BIT0) begin
						scl = next_step == '0;
						sda = 1'b0;
					end else if (next_step < I2C_STOP) begin
						scl = rel % I2C_PH == 6'h01;
						sda = frame[FRAME_MSB - 5'(rel / I2C_PH)];
					end else begin
						scl = next_step != I2C_STOP;
						sda = 1'b0;
					end
				end
				next_d_o[PIN_CLK] = scl;
				next_d_oe = SCL_OE;
				next_d_oe[PIN_SIN] = ~sda;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			strap <= MODE_SPI4;
			res_cnt <= '0;
			res_done <= 1'b0;
			busy <= 1'b0;
			step <= '0;
			tick_cnt <= '0;
			rd <= 1'b0;
			dc <= 1'b0;
			byte_q <= '0;
			cs_n <= 1'b1;
			rw <= 1'b0;
			en <= 1'b0;
			d_o <= '0;
			d_oe <= '0;
			rsp_valid <= 1'b0;
			rsp_byte <= '0;
		end else begin
			strap <= next_strap;
			res_cnt <= next_res_cnt;
			res_done <= next_res_done;
			busy <= next_busy;
			step <= next_step;
			tick_cnt <= next_tick_cnt;
			rd <= next_rd;
			dc <= next_dc;
			byte_q <= next_byte_q;
			cs_n <= next_cs_n;
			rw <= next_rw;
			en <= next_en;
			d_o <= next_d_o;
			d_oe <= next_d_oe;
			rsp_valid <= next_rsp_valid;
			rsp_byte <= next_rsp_byte;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign bus.bus_select_low = strap[0];
	assign bus.bus_select_high = strap[1];
	assign bus.reset_in_n = res_done;
	assign bus.cs_n = cs_n;
	assign bus.dc = dc;
	assign bus.rw = rw;
	assign bus.en = en;
	assign bus.host_d_o = d_o;
	assign bus.host_d_oe = d_oe;
	assign rsp_valid_o = rsp_valid;
	assign rsp_byte_o = rsp_byte;
endmodule : disp_bus_host

//--- disp_bus_assertions.sv
// disp_bus_assertions: pin-level checks of the device end of the display host bus
// assumes one system clock and reset shared by both ends of one link
`timescale 1ns/1ns
module disp_bus_checker (
	// system
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// link
	input wire logic bus_select_low,
	input wire logic bus_select_high,
	input wire logic reset_in_n,
	input wire logic cs_n,
	input wire logic dc,
	input wire logic rw,
	input wire logic en,
	input wire logic [7:0] host_d_o,
	input wire logic [7:0] host_d_oe,
	input wire logic [7:0] dev_d_o,
	input wire logic [7:0] dev_d_oe,
	input wire logic [7:0] d
);
	import disp_bus_pkg::*;
	logic m6800;
	logic m8080;
	logic sel_spi;
	logic sel_i2c;
	assign m6800 = bus_select_high & ~bus_select_low;
	assign m8080 = bus_select_high & bus_select_low;
	assign sel_spi = ~bus_select_high & ~bus_select_low;
	assign sel_i2c = ~bus_select_high & bus_select_low;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	// ****************************
	// device pin rules
	// ****************************
	quiet_deselect_a: assert property (cs_n [*8] |-> dev_d_oe == 8'h00)
		else $error("device drives the data lines while deselected");
	init_no_drive_a: assert property (!reset_in_n [*8] |-> dev_d_oe == 8'h00)
		else $error("device drives the data lines during its reset");
	host_reset_hold_a: assert property ($rose(resetn_i) |-> !reset_in_n [*8])
		else $error("device reset pin released too early");
	spi_no_drive_a: assert property (sel_spi [*8] |-> dev_d_oe == 8'h00)
		else $error("device drives a line in 4-wire serial mode");
	i2c_ack_only_a: assert property (sel_i2c [*8] |-> (dev_d_oe & ~ACK_OE) == 8'h00)
		else $error("device drives a line other than data out in I2C mode");
	i2c_open_drain_a: assert property (sel_i2c && dev_d_oe[PIN_SOUT] |-> !dev_d_o[PIN_SOUT])
		else $error("device drives I2C data high");
	par_read_dir_a: assert property ((m6800 || m8080) && dev_d_oe != 8'h00 |-> rw)
		else $error("device drives the data lines in a write");
	read_6800_a: assert property ($rose(en) && !cs_n && rw && m6800 |-> ##[2:8] dev_d_oe == 8'hFF)
		else $error("6800 read not answered");
	release_6800_a: assert property ($fell(en) && m6800 |-> ##[1:8] dev_d_oe == 8'h00)
		else $error("6800 read drive not released");
	read_8080_a: assert property ($fell(en) && !cs_n && m8080 |-> ##[2:8] dev_d_oe == 8'hFF)
		else $error("8080 read not answered");
	release_8080_a: assert property ($rose(en) && m8080 |-> ##[1:8] dev_d_oe == 8'h00)
		else $error("8080 read drive not released");
endmodule : disp_bus_checker

//--- tb_top.sv
// tb_top: host and device ends joined, plus a hand-driven second link
// assumes the package, the interface and both ends are compiled first
`timescale 1ns/1ns
module tb_top;
	import disp_bus_pkg::*;
	typedef struct packed {
		mode_t mode;
		logic rd;
		logic dc;
		logic [7:0] b;
	} row_t;
	logic clk_sys_i;
	logic resetn;
	mode_t mode;
	mode_t mode_seen;
	logic cmd_valid, cmd_read, cmd_is_data, cmd_ready, rsp_valid;
	logic [7:0] cmd_byte, rd_data, rsp_byte, wr_byte, wr_byte_b;
	logic wr_valid, wr_is_data, rd_req, rd_is_data, init_active, wr_valid_b, rd_req_b;
	logic prev_d0;
	logic [18:0] shift;
	int wr_cnt, rd_cnt, rsp_cnt, wr_cnt_b, rd_cnt_b;
	int bad_count;
	int checks_done;
	row_t rows [11] = '{'{MODE_6800, 0, 1, 8'hA5}, '{MODE_6800, 0, 0, 8'h00},
		'{MODE_6800, 1, 1, 8'h3C}, '{MODE_6800, 1, 0, 8'hFF}, '{MODE_8080, 0, 0, 8'hFF},
		'{MODE_8080, 1, 1, 8'h5A}, '{MODE_8080, 0, 1, 8'h81}, '{MODE_SPI4, 0, 1, 8'h96},
		'{MODE_SPI4, 0, 0, 8'h01}, '{MODE_I2C, 0, 0, 8'hC3}, '{MODE_I2C, 0, 1, 8'h7E}};

	disp_bus_if bus ();
	disp_bus_if bus_b ();
	disp_bus_host i_disp_bus_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn), .bus(bus),
		.mode_i(mode), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
		.cmd_read_i(cmd_read), .cmd_is_data_i(cmd_is_data), .cmd_byte_i(cmd_byte),
		.rsp_valid_o(rsp_valid), .rsp_byte_o(rsp_byte));
	disp_bus_dev i_disp_bus_dev (.clk_sys_i(clk_sys_i), .resetn_i(resetn), .bus(bus),
		.wr_valid_o(wr_valid), .wr_byte_o(wr_byte), .wr_is_data_o(wr_is_data),
		.rd_req_o(rd_req), .rd_is_data_o(rd_is_data), .rd_data_i(rd_data),
		.mode_o(mode_seen), .init_active_o(init_active));
	disp_bus_dev i_disp_bus_dev_b (.clk_sys_i(clk_sys_i), .resetn_i(resetn), .bus(bus_b),
		.wr_valid_o(wr_valid_b), .wr_byte_o(wr_byte_b), .wr_is_data_o(),
		.rd_req_o(rd_req_b), .rd_is_data_o(), .rd_data_i(8'h00), .mode_o(), .init_active_o());
	disp_bus_checker i_disp_bus_checker (.clk_sys_i(clk_sys_i), .resetn_i(resetn),
		.bus_select_low(bus.bus_select_low), .bus_select_high(bus.bus_select_high),
		.reset_in_n(bus.reset_in_n), .cs_n(bus.cs_n), .dc(bus.dc), .rw(bus.rw), .en(bus.en),
		.host_d_o(bus.host_d_o), .host_d_oe(bus.host_d_oe), .dev_d_o(bus.dev_d_o),
		.dev_d_oe(bus.dev_d_oe), .d(bus.d));

	// ****************************
	// clock, pulse counters, serial bit capture
	// ****************************
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (wr_valid === 1'b1) wr_cnt++;
		if (rd_req === 1'b1) rd_cnt++;
		if (rsp_valid === 1'b1) rsp_cnt++;
		if (wr_valid_b === 1'b1) wr_cnt_b++;
		if (rd_req_b === 1'b1) rd_cnt_b++;
		if (bus.d[0] === 1'b1 && prev_d0 === 1'b0 && bus.cs_n === 1'b0) shift <= {shift[17:0], bus.d[1]};
		prev_d0 <= bus.d[0];
	end

	// ****************************
	// tasks
	// ****************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			n++;
			@(negedge clk_sys_i);
		end
		if (n == 3000) bad_count++;
	endtask : wait_ready
	task automatic reset_to(input mode_t m);
		resetn = 1'b0;
		mode = m;
		repeat (10) @(negedge clk_sys_i);
		resetn = 1'b1;
		@(negedge clk_sys_i);
		check(init_active, 1'b1);
		wait_ready();
		repeat (8) @(negedge clk_sys_i);
		check({init_active, mode_seen}, {1'b0, m});
	endtask : reset_to
	task automatic run_op(input row_t r);
		int w0;
		int q0;
		int s0;
		int n;
		w0 = wr_cnt;
		q0 = rd_cnt;
		s0 = rsp_cnt;
		n = 0;
		{cmd_read, cmd_is_data, cmd_byte, rd_data} = {r.rd, r.dc, r.b, r.b};
		cmd_valid = 1'b1;
		wait_ready();
		@(negedge clk_sys_i);
		cmd_valid = 1'b0;
		while (wr_cnt == w0 && rsp_cnt == s0 && n < 3000) begin
			n++;
			@(negedge clk_sys_i);
		end
		if (n == 3000) bad_count++;
		wait_ready();
		repeat (8) @(negedge clk_sys_i);
		check(wr_cnt - w0, !r.rd);
		check(rsp_cnt - s0, r.rd);
		if (r.rd) begin
			check(rd_cnt - q0, 1);
			check({rd_is_data, rsp_byte}, {r.dc, r.b});
		end else begin
			check({wr_is_data, wr_byte}, {r.dc, r.b});
			check(rd_cnt - q0, 0);
		end
		if (r.mode == MODE_SPI4) check(bus.d[7:2], 6'h00);
		if (r.mode == MODE_SPI4) check({bus.rw, bus.en, shift[7:0]}, {2'b00, r.b});
		if (r.mode == MODE_I2C) check({bus.rw, bus.en, shift}, {2'b00, I2C_ADDR_HI, 3'b000, r.b, 2'b00});
	endtask : run_op
	task automatic pulse_b(input logic cs, input logic dir);
		bus_b.cs_n = cs;
		bus_b.rw = dir;
		repeat (8) @(negedge clk_sys_i);
		bus_b.en = 1'b1;
		repeat (12) @(negedge clk_sys_i);
		check(bus_b.dev_d_oe, (!cs && dir) ? 8'hFF : 8'h00);
		bus_b.en = 1'b0;
		repeat (12) @(negedge clk_sys_i);
		bus_b.cs_n = 1'b1;
		repeat (8) @(negedge clk_sys_i);
	endtask : pulse_b

	// ****************************
	// main sequence and watchdog
	// ****************************
	initial begin
		{resetn, cmd_valid, cmd_read, cmd_is_data, cmd_byte, rd_data} = '0;
		mode = MODE_SPI4;
		{wr_cnt, rd_cnt, rsp_cnt, wr_cnt_b, rd_cnt_b, bad_count, checks_done} = '0;
		{prev_d0, shift} = '0;
		{bus_b.bus_select_low, bus_b.bus_select_high, bus_b.reset_in_n, bus_b.rw, bus_b.en} = '0;
		{bus_b.cs_n, bus_b.dc, bus_b.host_d_oe, bus_b.host_d_o} = {2'b11, 8'hFF, 8'h5A};
		foreach (rows[i]) begin
			if (i == 0 || rows[i].mode != rows[i - 1].mode) reset_to(rows[i].mode);
			run_op(rows[i]);
		end
		bus_b.bus_select_high = 1'b1;
		repeat (10) @(negedge clk_sys_i);
		bus_b.reset_in_n = 1'b1;
		repeat (10) @(negedge clk_sys_i);
		pulse_b(1'b1, 1'b0);
		pulse_b(1'b1, 1'b1);
		check(wr_cnt_b + rd_cnt_b, 0);
		pulse_b(1'b0, 1'b0);
		check({wr_cnt_b[7:0], wr_byte_b}, {8'h01, 8'h5A});
		pulse_b(1'b0, 1'b1);
		check(rd_cnt_b, 1);
		conclude();
	end
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		bad_count++;
		conclude();
	end
endmodule : tb_top
